// ===== ccir656_params.svh
`ifndef CCIR656_PARAMS_SVH
`define CCIR656_PARAMS_SVH

// Pixel word and timing reference code layout.
`define PIX_W 8
`define WORD_FF 8'hff
`define WORD_00 8'h00
`define TRS_ONE_BIT 7
`define TRS_F_BIT 6
`define TRS_V_BIT 5
`define TRS_H_BIT 4

// Register index and reset value.
`define REG_ANC_TYPE 8'h07
`define ANC_TYPE_RST 8'h00
`define REG_READ_ZERO 8'h00

// Ancillary word layout; bit 0 carries parity.
`define ANC_LO 1
`define ANC_HI 7
`define ANC_VALID_BIT 7
`define ANC_SVF_BIT 4
`define ANC_FLD_HI 3
`define ANC_PH_HI 6
`define ANC_FR4_HI 4
`define HDR_LAST 4'h2
`define BODY_FIELD 4'h2
`define BODY_PH1 4'h3
`define BODY_PH0 4'h4
`define BODY_FR4 4'h5
`define BODY_LAST 4'h9
`define IDX_ONE 4'h1
`define IDX_ZERO 4'h0

// Widths of the decoded values.
`define FIELD_W 3
`define PHASE_W 13
`define FREQ_W 32
`define PHASE_STEPS 8192

// Line timing, in words from the leading edge of line sync to active video.
`define LINE_CNT_W 12
`define SYNC_OFS_525 12'h0f4
`define SYNC_OFS_625 12'h108
`define CNT_ONE 12'h001
`define CNT_TWO 12'h002
`define CNT_ZERO 12'h000

`endif

// ===== ccir656_pkg.sv
package ccir656_pkg;
   typedef enum logic [1:0] {kind_cb, kind_y, kind_cr} comp_kind_t;
   typedef enum logic [1:0] {st_idle, st_hdr, st_type, st_body} anc_state_t;
endpackage : ccir656_pkg

// ===== pin_sync2.sv
`timescale 1ns/1ps
module pin_sync2 #(
   parameter int WIDTH = 9
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Asynchronous in, synchronised out
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end

   assign q = sync_q;
endmodule : pin_sync2

// ===== skid_buffer2.sv
`timescale 1ns/1ps
module skid_buffer2 #(
   parameter int WIDTH = 10
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Filling side
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // Draining side
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   logic [WIDTH-1:0] out_data_q;
   logic out_valid_q;
   logic [WIDTH-1:0] skid_data_q;
   logic skid_valid_q;

   assign in_ready = ~skid_valid_q;
   assign out_data = out_data_q;
   assign out_valid = out_valid_q;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         out_data_q <= '0;
         out_valid_q <= 1'b0;
         skid_data_q <= '0;
         skid_valid_q <= 1'b0;
      end else if (!out_valid_q || out_ready) begin
         if (skid_valid_q) begin
            out_data_q <= skid_data_q;
            out_valid_q <= 1'b1;
            skid_valid_q <= 1'b0;
         end else begin
            out_data_q <= in_data;
            out_valid_q <= in_valid;
         end
      end else if (in_valid && !skid_valid_q) begin
         skid_data_q <= in_data;
         skid_valid_q <= 1'b1;
      end
   end

   a_stall_holds: assert property (@(posedge core_clk) disable iff (rst)
      out_valid_q && !out_ready |=> out_valid_q && $stable(out_data_q))
      else $error("Output word changed during a stall.");
   c_buffer_full: cover property (@(posedge core_clk) disable iff (rst)
      skid_valid_q && out_valid_q);
endmodule : skid_buffer2

// ===== ccir656_timing_anc_decoder.sv
`timescale 1ns/1ps
`include "ccir656_params.svh"
module ccir656_timing_anc_decoder (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Pixel port pins
   input wire logic pixel_clock_in,
   input wire logic [`PIX_W-1:0] pixel_bus,
   // Register port
   input wire logic [7:0] reg_index,
   input wire logic reg_write,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Control inputs
   input wire logic anc_timing_load_enable,
   input wire logic anc_phase_load_enable,
   input wire logic anc_freq_load_enable,
   input wire logic std_625,
   input wire logic [`FREQ_W-1:0] prog_freq_word,
   // Component stream
   output logic [`PIX_W-1:0] comp_data,
   output logic [1:0] comp_kind,
   output logic comp_valid,
   input wire logic comp_ready,
   output logic word_lost,
   // Timing status
   output logic field_odd,
   output logic field_start,
   output logic line_blank,
   output logic [`FIELD_W-1:0] field_count,
   output logic line_sync,
   // Subcarrier controls
   output logic phase_reset,
   output logic [`PHASE_W-1:0] subcarrier_phase_word,
   output logic [`FREQ_W-1:0] osc_addend
);
   logic [`PIX_W:0] pin_sync;
   logic [`PIX_W-1:0] word, h1_q, h2_q, h3_q, hdr_word;
   logic pck_q, word_stb, in_packet, trs_stat, is_eav, is_sav, type_hit, anc_commit;
   logic svf_n_q, phv_q, frv_q, anc_freq_have_q, pend_q, phase_reset_q;
   logic field_q, field_start_q, blank_q, have_start_q, line_sync_q;
   logic act_q, vid_ok, word_lost_q, buf_in_ready;
   ccir656_pkg::anc_state_t st_q;
   ccir656_pkg::comp_kind_t kind;
   logic [3:0] idx_q;
   logic [1:0] cphase_q;
   logic [`FIELD_W-1:0] fld_num_q, field_count_q;
   logic [`PHASE_W-1:0] ph_sh_q, stage_q, phase_out_q;
   logic [`FREQ_W-1:0] fr_sh_q, fr_full, anc_freq_q, osc_addend_q;
   logic [`LINE_CNT_W-1:0] line_cnt_q, act_start_q, sync_ofs, sync_pos;
   logic [`PIX_W+1:0] buf_out;
   logic [7:0] type_match_q, reg_rdata_q;
   pin_sync2 #(.WIDTH(`PIX_W + 1)) u_pin_sync (.core_clk(core_clk), .rst(rst),
      .d({pixel_clock_in, pixel_bus}), .q(pin_sync));
   // A word is taken on each rising edge of the synchronised pixel clock.
   assign word_stb = pin_sync[`PIX_W] & ~pck_q;
   assign word = pin_sync[`PIX_W-1:0];

   always_ff @(posedge core_clk) begin
      if (rst) begin
         pck_q <= 1'b0;
         h1_q <= `WORD_00;
         h2_q <= `WORD_00;
         h3_q <= `WORD_00;
      end else begin
         pck_q <= pin_sync[`PIX_W];
         if (word_stb) begin
            h1_q <= word;
            h2_q <= h1_q;
            h3_q <= h2_q;
         end
      end
   end

   // Packet words may hold any value, so no timing code is searched for inside them.
   assign in_packet = (st_q == ccir656_pkg::st_type) || (st_q == ccir656_pkg::st_body);
   assign trs_stat = word_stb && !in_packet && h3_q == `WORD_FF && h2_q == `WORD_00 &&
                     h1_q == `WORD_00 && word[`TRS_ONE_BIT];
   assign is_eav = trs_stat && word[`TRS_H_BIT];
   assign is_sav = trs_stat && !word[`TRS_H_BIT];

   // Field and blanking status follow end codes only and hold until the next one.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         field_q <= 1'b0;
         field_start_q <= 1'b0;
         blank_q <= 1'b1;
      end else begin
         field_start_q <= 1'b0;
         if (is_eav) begin
            field_q <= word[`TRS_F_BIT];
            field_start_q <= word[`TRS_F_BIT] != field_q;
            blank_q <= word[`TRS_V_BIT];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         field_count_q <= '0;
      end else if (anc_commit && !svf_n_q && anc_timing_load_enable) begin
         field_count_q <= fld_num_q;
      end else if (field_start_q) begin
         field_count_q <= field_count_q + `FIELD_W'(1);
      end
   end

   // Line sync edge is placed the standard offset before the active line start.
   assign sync_ofs = std_625 ? `SYNC_OFS_625 : `SYNC_OFS_525;
   assign sync_pos = act_start_q - sync_ofs;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         line_cnt_q <= `CNT_ZERO;
      end else if (is_eav) begin
         line_cnt_q <= `CNT_ZERO;
      end else if (word_stb) begin
         line_cnt_q <= line_cnt_q + `CNT_ONE;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         act_start_q <= `CNT_ZERO;
         have_start_q <= 1'b0;
      end else if (is_sav) begin
         act_start_q <= line_cnt_q + `CNT_TWO;
         have_start_q <= 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         line_sync_q <= 1'b0;
      end else begin
         line_sync_q <= word_stb && !is_eav && have_start_q && act_start_q >= sync_ofs &&
                        (line_cnt_q + `CNT_ONE) == sync_pos;
      end
   end

   // Active video words are split by position after the start code.
   assign vid_ok = word_stb && act_q && !trs_stat && word != `WORD_FF && word != `WORD_00;
   assign kind = cphase_q[0] ? ccir656_pkg::kind_y :
                 (cphase_q[1] ? ccir656_pkg::kind_cr : ccir656_pkg::kind_cb);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         act_q <= 1'b0;
         cphase_q <= 2'h0;
      end else if (is_sav) begin
         act_q <= 1'b1;
         cphase_q <= 2'h0;
      end else if (is_eav) begin
         act_q <= 1'b0;
      end else if (vid_ok) begin
         cphase_q <= cphase_q + 2'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         word_lost_q <= 1'b0;
      end else if (vid_ok && !buf_in_ready) begin
         word_lost_q <= 1'b1;
      end
   end

   skid_buffer2 #(.WIDTH(`PIX_W + 2)) u_comp_buf (.core_clk(core_clk), .rst(rst),
      .in_data({kind, word}), .in_valid(vid_ok), .in_ready(buf_in_ready),
      .out_data(buf_out), .out_valid(comp_valid), .out_ready(comp_ready));
   // Ancillary packet parser.
   assign hdr_word = (idx_q == `IDX_ZERO) ? `WORD_00 : `WORD_FF;
   assign type_hit = word[`ANC_HI:`ANC_LO] == type_match_q[`ANC_HI:`ANC_LO];
   assign fr_full = {fr_sh_q[`FREQ_W-8:0], word[`ANC_HI:`ANC_LO]};
   assign anc_commit = word_stb && st_q == ccir656_pkg::st_body && idx_q == `BODY_LAST;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_q <= ccir656_pkg::st_idle;
         idx_q <= `IDX_ZERO;
         svf_n_q <= 1'b1;
         fld_num_q <= '0;
         phv_q <= 1'b0;
         ph_sh_q <= '0;
         frv_q <= 1'b0;
         fr_sh_q <= '0;
      end else if (is_eav) begin
         st_q <= ccir656_pkg::st_hdr;
         idx_q <= `IDX_ZERO;
      end else if (word_stb) begin
         unique case (st_q)
            ccir656_pkg::st_idle: ;
            ccir656_pkg::st_hdr: begin
               if (word != hdr_word) begin
                  st_q <= ccir656_pkg::st_idle;
               end else if (idx_q == `HDR_LAST) begin
                  st_q <= ccir656_pkg::st_type;
                  idx_q <= `IDX_ZERO;
               end else begin
                  idx_q <= idx_q + `IDX_ONE;
               end
            end
            ccir656_pkg::st_type: begin
               st_q <= type_hit ? ccir656_pkg::st_body : ccir656_pkg::st_idle;
            end
            ccir656_pkg::st_body: begin
               if (idx_q == `BODY_FIELD) begin
                  svf_n_q <= word[`ANC_SVF_BIT];
                  fld_num_q <= word[`ANC_FLD_HI:`ANC_LO];
               end else if (idx_q == `BODY_PH1) begin
                  phv_q <= word[`ANC_VALID_BIT];
                  ph_sh_q <= {7'h00, word[`ANC_PH_HI:`ANC_LO]};
               end else if (idx_q == `BODY_PH0) begin
                  ph_sh_q <= {ph_sh_q[5:0], word[`ANC_HI:`ANC_LO]};
               end else if (idx_q == `BODY_FR4) begin
                  frv_q <= word[`ANC_VALID_BIT];
                  fr_sh_q <= {28'h0000000, word[`ANC_FR4_HI:`ANC_LO]};
               end else if (idx_q > `BODY_FR4) begin
                  fr_sh_q <= fr_full;
               end
               if (idx_q == `BODY_LAST) begin
                  st_q <= ccir656_pkg::st_idle;
               end
               idx_q <= idx_q + `IDX_ONE;
            end
         endcase
      end
   end

   // Phase steps are 1/PHASE_STEPS of a cycle; a new value waits for the sync tip.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pend_q <= 1'b0;
         stage_q <= '0;
         phase_out_q <= '0;
         phase_reset_q <= 1'b0;
      end else begin
         phase_reset_q <= 1'b0;
         if (line_sync_q && pend_q) begin
            phase_reset_q <= 1'b1;
            phase_out_q <= stage_q;
            pend_q <= 1'b0;
         end
         if (anc_commit && phv_q && anc_phase_load_enable) begin
            pend_q <= 1'b1;
            stage_q <= ph_sh_q;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         anc_freq_q <= '0;
         anc_freq_have_q <= 1'b0;
         osc_addend_q <= '0;
      end else begin
         if (anc_commit && frv_q && anc_freq_load_enable) begin
            anc_freq_q <= fr_full;
            anc_freq_have_q <= 1'b1;
         end
         osc_addend_q <= (anc_freq_load_enable && anc_freq_have_q) ? anc_freq_q :
                         prog_freq_word;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         type_match_q <= `ANC_TYPE_RST;
         reg_rdata_q <= `REG_READ_ZERO;
      end else begin
         if (reg_write && reg_index == `REG_ANC_TYPE) begin
            type_match_q <= reg_wdata;
         end
         reg_rdata_q <= (reg_index == `REG_ANC_TYPE) ? type_match_q : `REG_READ_ZERO;
      end
   end

   assign reg_rdata = reg_rdata_q;
   assign comp_data = buf_out[`PIX_W-1:0];
   assign comp_kind = buf_out[`PIX_W+1:`PIX_W];
   assign {word_lost, field_odd, field_start, line_blank} =
          {word_lost_q, field_q, field_start_q, blank_q};
   assign {field_count, line_sync, phase_reset} = {field_count_q, line_sync_q, phase_reset_q};
   assign subcarrier_phase_word = phase_out_q;
   assign osc_addend = osc_addend_q;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   a_eav_field_bit: assert property (is_eav |=> field_q == $past(word[`TRS_F_BIT]))
      else $error("Field bit not taken from end code.");
   a_sav_no_effect: assert property (is_sav |=> $stable(field_q) && $stable(blank_q))
      else $error("Start code changed field or blanking.");
   a_field_change: assert property (is_eav && word[`TRS_F_BIT] != field_q |=>
      field_start_q ##1 !field_start_q)
      else $error("Field change not flagged for one cycle.");
   a_blank_follow: assert property (is_eav |=> blank_q == $past(word[`TRS_V_BIT]))
      else $error("Blanking bit not applied.");
   a_sync_offset: assert property (line_sync_q |->
      ($past(line_cnt_q) + `CNT_ONE + $past(sync_ofs)) == act_start_q)
      else $error("Line sync not at the standard offset.");
   a_type_reject: assert property (st_q == ccir656_pkg::st_type && word_stb && !type_hit
      |=> st_q == ccir656_pkg::st_idle)
      else $error("Packet of other type not ignored.");
   a_field_load: assert property (anc_commit && !svf_n_q && anc_timing_load_enable
      |=> field_count_q == $past(fld_num_q))
      else $error("Field number not loaded.");
   a_phase_sync_tip: assert property (phase_reset_q |->
      $past(line_sync_q) && subcarrier_phase_word == $past(stage_q))
      else $error("Phase reset outside sync tip.");
   a_freq_addend: assert property (anc_commit && frv_q && anc_freq_load_enable
      |=> ##1 osc_addend_q == $past(fr_full, 2))
      else $error("Latched frequency not used as addend.");
   c_end_code: cover property (is_eav ##1 field_start_q);
   c_packet_done: cover property (anc_commit);
   c_phase_reset: cover property (phase_reset_q);
   c_comp_stall: cover property (comp_valid && !comp_ready ##1 comp_valid && comp_ready);
endmodule : ccir656_timing_anc_decoder

// ===== pixel_source.sv
`timescale 1ns/1ps
module pixel_source (
   // Clock
   input wire logic core_clk,
   // Pixel port toward the device
   output logic pixel_clock_in,
   output logic [7:0] pixel_bus
);
   int pos = 0;

   initial begin
      pixel_clock_in = 1'b0;
      pixel_bus = 8'h00;
   end

   // The word stands only while the pixel clock is high; once it falls the bus shows the inverse.
   task automatic send_word(input logic [7:0] w);
      pos = pos + 1;
      @(posedge core_clk);
      pixel_bus <= w;
      pixel_clock_in <= 1'b1;
      repeat (3) @(posedge core_clk);
      pixel_clock_in <= 1'b0;
      pixel_bus <= ~w;
      repeat (2) @(posedge core_clk);
   endtask : send_word

   task automatic send_code(input logic f, v, eav, input logic [3:0] prot);
      send_word(8'hff);
      send_word(8'h00);
      send_word(8'h00);
      if (eav) pos = -1;
      send_word({1'b1, f, v, eav, prot});
   endtask : send_code

   task automatic send_packet(input logic [6:0] tt, input logic svf_n, input logic [2:0] fld,
      input logic pv, input logic [12:0] ph, input logic fv, input logic [31:0] fr,
      input logic [13:0] par);
      logic [7:0] w [14];
      w = '{8'h00, 8'hff, 8'hff, {tt, par[3]}, {7'h00, par[4]}, {7'h00, par[5]},
         {3'b000, svf_n, fld, par[6]}, {pv, ph[12:7], par[7]}, {ph[6:0], par[8]},
         {fv, 2'b00, fr[31:28], par[9]}, {fr[27:21], par[10]}, {fr[20:14], par[11]},
         {fr[13:7], par[12]}, {fr[6:0], par[13]}};
      foreach (w[i]) send_word(w[i]);
   endtask : send_packet
endmodule : pixel_source

// ===== tb_ccir656_timing_anc_decoder.sv
`timescale 1ns/1ps
module tb_ccir656_timing_anc_decoder;
   localparam logic [6:0] type_id = 7'h2a;
   logic core_clk, rst, reg_write, comp_valid, comp_ready, word_lost, field_odd, field_start;
   logic line_blank, line_sync, phase_reset, pixel_clock_in, std_625, stall, ls_q;
   logic anc_timing_load_enable, anc_phase_load_enable, anc_freq_load_enable;
   logic [7:0] pixel_bus, reg_index, reg_wdata, reg_rdata, comp_data;
   logic [1:0] comp_kind;
   logic [2:0] field_count;
   logic [12:0] subcarrier_phase_word, cur_ph, exp_ph;
   logic [31:0] prog_freq_word, osc_addend, cur_fr, fr_kept;
   logic [9:0] exp_q[$];
   integer seed;
   int failures = 0, num_checks = 0, fs_cnt = 0, ph_cnt = 0, ls_cnt = 0;

   pixel_source i_src (.core_clk, .pixel_clock_in, .pixel_bus);

   ccir656_timing_anc_decoder i_dut (.core_clk, .rst, .pixel_clock_in, .pixel_bus, .reg_index,
      .reg_write, .reg_wdata, .reg_rdata, .anc_timing_load_enable, .anc_phase_load_enable,
      .anc_freq_load_enable, .std_625, .prog_freq_word, .comp_data, .comp_kind, .comp_valid,
      .comp_ready, .word_lost, .field_odd, .field_start, .line_blank, .field_count, .line_sync,
      .phase_reset, .subcarrier_phase_word, .osc_addend);

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   task automatic conclude();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : conclude

   task automatic chk_val(input logic [31:0] got, e);
      num_checks++;
      if (got !== e) begin
         failures++;
         $display("BAD %0t got %h exp %h", $time, got, e);
      end
   endtask : chk_val

   task automatic chk_word(input logic [9:0] got, e);
      chk_val({22'h0, got}, {22'h0, e});
   endtask : chk_word

   task automatic chk_line(input logic f, v, input logic [2:0] n, input logic [31:0] a,
      input int fs);
      chk_val({field_odd, line_blank, field_count, fs_cnt[3:0]}, {f, v, n, fs[3:0]});
      chk_val(osc_addend, a);
   endtask : chk_line

   task automatic reg_wr(input logic [7:0] idx, d);
      @(posedge core_clk);
      reg_index <= idx;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [7:0] idx, e);
      @(posedge core_clk);
      reg_index <= idx;
      repeat (2) @(posedge core_clk);
      chk_val(reg_rdata, e);
   endtask : reg_rd

   // One line: end code, optional packet, filler, start code at 260 (280 in 625), four words.
   task automatic send_line(input logic f, v, pkt, input logic [6:0] tt, input logic svf_n,
      input logic [2:0] fld, input logic pv, fv);
      logic [7:0] w;
      logic [1:0] k;
      i_src.send_code(f, v, 1'b1, 4'($random(seed)));
      if (pkt) i_src.send_packet(tt, svf_n, fld, pv, cur_ph, fv, cur_fr, 14'($random(seed)));
      while (i_src.pos < 259 + 20 * std_625) i_src.send_word(8'h10);
      i_src.send_code(!f, !v, 1'b0, 4'h0);
      for (int i = 0; i < 4; i++) begin
         w = 8'h10 + 8'($random(seed) & 32'h7f);
         k = i[0] ? ccir656_pkg::kind_y : (i == 0 ? ccir656_pkg::kind_cb : ccir656_pkg::kind_cr);
         if (!stall || i < 2) exp_q.push_back({k, w});
         i_src.send_word(w);
      end
   endtask : send_line

   always @(posedge core_clk) comp_ready <= !stall && (!comp_ready || 1'($random(seed)));

   always @(posedge core_clk) begin
      ls_q <= line_sync;
      if (field_start === 1'b1) fs_cnt++;
      if (line_sync === 1'b1) begin
         ls_cnt++;
         chk_val(i_src.pos, 32'd20);
      end
      if (phase_reset === 1'b1) begin
         ph_cnt++;
         chk_val({ls_q, subcarrier_phase_word}, {1'b1, exp_ph});
      end
      if (comp_valid === 1'b1 && comp_ready === 1'b1) begin
         chk_word({comp_kind, comp_data}, exp_q.size() ? exp_q.pop_front() : 10'h3ff);
      end
   end

   initial begin
      repeat (30000) @(posedge core_clk);
      failures++;
      conclude();
   end

   initial begin
      seed = 32'h3d5943d4;
      rst = 1'b1;
      reg_index = 8'h00;
      reg_write = 1'b0;
      reg_wdata = 8'h00;
      std_625 = 1'b0;
      anc_timing_load_enable = 1'b1;
      anc_phase_load_enable = 1'b1;
      anc_freq_load_enable = 1'b1;
      prog_freq_word = $random(seed);
      comp_ready = 1'b0;
      stall = 1'b0;
      ls_q = 1'b0;
      cur_ph = 13'h0000;
      cur_fr = 32'h0;
      exp_ph = 13'h0000;
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk_line(1'b0, 1'b1, 3'h0, prog_freq_word, 0);
      reg_rd(8'h07, 8'h00);
      reg_wr(8'h07, {type_id, 1'b1});
      reg_wr(8'h08, 8'hff);
      reg_rd(8'h08, 8'h00);
      reg_rd(8'h07, {type_id, 1'b1});
      send_line(1'b0, 1'b1, 1'b0, type_id, 1'b0, 3'h0, 1'b0, 1'b0);
      chk_line(1'b0, 1'b1, 3'h0, prog_freq_word, 0);
      cur_ph = 13'($random(seed));
      cur_fr = $random(seed);
      exp_ph = cur_ph;
      send_line(1'b1, 1'b0, 1'b1, type_id, 1'b0, 3'h5, 1'b1, 1'b1);
      chk_line(1'b1, 1'b0, 3'h5, cur_fr, 1);
      fr_kept = cur_fr;
      cur_ph = ~cur_ph;
      cur_fr = ~cur_fr;
      send_line(1'b1, 1'b0, 1'b1, type_id ^ 7'h01, 1'b0, 3'h2, 1'b1, 1'b1);
      chk_line(1'b1, 1'b0, 3'h5, fr_kept, 1);
      anc_freq_load_enable <= 1'b0;
      anc_phase_load_enable <= 1'b0;
      send_line(1'b0, 1'b1, 1'b1, type_id, 1'b1, 3'h1, 1'b1, 1'b1);
      chk_line(1'b0, 1'b1, 3'h6, prog_freq_word, 2);
      anc_freq_load_enable <= 1'b1;
      anc_phase_load_enable <= 1'b1;
      send_line(1'b0, 1'b0, 1'b1, type_id, 1'b0, 3'h3, 1'b0, 1'b0);
      chk_line(1'b0, 1'b0, 3'h3, fr_kept, 2);
      chk_val({31'h0, word_lost}, 32'h0);
      stall <= 1'b1;
      send_line(1'b0, 1'b0, 1'b0, type_id, 1'b0, 3'h0, 1'b0, 1'b0);
      stall <= 1'b0;
      repeat (20) @(posedge core_clk);
      chk_val({word_lost, 31'(exp_q.size())}, 32'h80000000);
      std_625 <= 1'b1;
      anc_timing_load_enable <= 1'b0;
      send_line(1'b1, 1'b0, 1'b1, type_id, 1'b0, 3'h7, 1'b0, 1'b0);
      send_line(1'b1, 1'b0, 1'b0, type_id, 1'b0, 3'h0, 1'b0, 1'b0);
      chk_line(1'b1, 1'b0, 3'h4, fr_kept, 3);
      repeat (20) @(posedge core_clk);
      chk_val({ph_cnt[7:0], ls_cnt[7:0], 16'(exp_q.size())}, 32'h01060000);
      conclude();
   end
endmodule : tb_ccir656_timing_anc_decoder
